// *** hw/fsps_top.v ***
/*
 flash self-program sequencer: table read/write port for the core,
 64-word holding buffer, unlock key, row/word program and page erase.
 assumes a synchronous core port on mclk, apb master on mclk, and a
 flash array that accepts one word per cycle while busy is high.
*/
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ns
`include "fsps_map.vh"
module fsps_top #(
  parameter AW = 16
) (
  input  wire          mclk,
  input  wire          sys_rst,
  input  wire          clk_en,
  // apb slave
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [11:0]   paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata,
  output wire          pready,
  output wire          pslverr,
  // core table port
  input  wire          tbl_req,
  input  wire          tbl_write,
  input  wire          tbl_high,
  input  wire          tbl_byte,
  input  wire          tbl_bsel,
  input  wire [15:0]   effective_address,
  input  wire [15:0]   tbl_wdata,
  output reg  [15:0]   tbl_rdata,
  output wire          tbl_done,
  output wire          core_stall,
  // flash array port
  output reg  [23:0]   fl_addr,
  output reg  [23:0]   fl_wdata,
  output reg           fl_we,
  output reg           fl_erase,
  output reg           fl_rd,
  input  wire [23:0]   fl_rdata,
  // serial programming pins
  input  wire          prog_clock_pin,
  input  wire          prog_data_pin_in,
  output wire          prog_data_pin_out,
  output wire          prog_data_pin_oe_n,
  output reg           serial_prog_active
);
  localparam S_IDLE = 3'd0, S_TWR = 3'd1, S_TRD = 3'd2, S_TRD2 = 3'd3;
  localparam S_ROW = 3'd4, S_ERASE = 3'd5, S_WORD = 3'd6, S_WAIT = 3'd7;

  reg  [15:0] flash_control_reg;
  reg  [7:0]  table_page_reg;
  reg  [1:0]  key_state;
  reg  [2:0]  state;
  reg  [15:0] timer;
  reg  [23:0] base_addr;
  reg  [5:0]  buf_ptr;
  reg  [9:0]  op_cnt;
  reg  [23:0] hold_word;
  reg  [1:0]  pgc_sync;
  reg  [1:0]  pgd_sync;
  wire        buf_we;
  wire [5:0]  buf_addr;
  wire [23:0] buf_rdata;
  wire [23:0] buf_wdata;
  wire [23:0] tbl_addr;
  wire        apb_wr;
  wire        apb_rd;
  wire        busy;
  wire [3:0]  op_sel;

  assign apb_wr  = psel & penable & pwrite;
  assign apb_rd  = psel & ~penable & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign op_sel  = flash_control_reg[`FSPS_OP_HI:`FSPS_OP_LO];
  assign busy    = (state == S_ROW) | (state == S_ERASE) | (state == S_WORD);
  // program word address from page byte and effective address
  assign tbl_addr = {table_page_reg, effective_address};
  assign core_stall = busy | flash_control_reg[`FSPS_WR_BIT];
  assign tbl_done   = (state == S_TWR) | (state == S_TRD2);

  // table write merges into the staged word: low/high and byte lanes
  assign buf_wdata = tbl_high ?
    {(tbl_byte ? tbl_wdata[7:0] : tbl_wdata[7:0]), hold_word[15:0]} :
    (tbl_byte ? (tbl_bsel ? {hold_word[23:16], tbl_wdata[7:0], hold_word[7:0]}
                          : {hold_word[23:8], tbl_wdata[7:0]})
              : {hold_word[23:16], tbl_wdata});
  assign buf_we   = (state == S_IDLE) & clk_en & tbl_req & tbl_write & ~core_stall;
  // buffer slot from low address bits, grouping words per row
  assign buf_addr = busy ? buf_ptr : tbl_addr[6:1];

  // the array programs from the staged buffer only
  fsps_mem #(
    .AW (6),
    .DW (24)
  ) u_buf (
    .mclk  (mclk),
    .ce    (clk_en),
    .we    (buf_we),
    .addr  (buf_addr),
    .wdata (buf_wdata),
    .rdata (buf_rdata)
  );

  // serial programming pins: synchronised, device only listens
  // limitation: pins are only watched, the serial protocol is not decoded
  assign prog_data_pin_out  = 1'b0;
  assign prog_data_pin_oe_n = 1'b1;
  always @(posedge mclk) begin
    if (sys_rst) begin
      pgc_sync <= 2'b00;
      pgd_sync <= 2'b00;
      serial_prog_active <= 1'b0;
    end else if (clk_en) begin
      pgc_sync <= {pgc_sync[0], prog_clock_pin};
      pgd_sync <= {pgd_sync[0], prog_data_pin_in};
      serial_prog_active <= pgc_sync[1] | pgd_sync[1];
    end
  end

  // apb read mux
  always @(posedge mclk) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en && apb_rd) begin
      case (paddr)
        `FSPS_CTRL_OFF: prdata <= {16'h0000, flash_control_reg};
        `FSPS_PAGE_OFF: prdata <= {24'h000000, table_page_reg};
        `FSPS_STAT_OFF: prdata <= {28'h0000000, serial_prog_active, busy, key_state};
        default:        prdata <= 32'h0000_0000;
      endcase
    end
  end

  // key unlock, control register and start handling
  always @(posedge mclk) begin
    if (sys_rst) begin
      flash_control_reg <= `FSPS_CTRL_RST;
      table_page_reg    <= `FSPS_PAGE_RST;
      key_state         <= 2'd0;
    end else if (clk_en) begin
      if (apb_wr && paddr == `FSPS_KEY_OFF) begin
        // two consecutive key writes arm the start
        if (pwdata[7:0] == `FSPS_KEY1) begin
          key_state <= 2'd1;
        end else if (pwdata[7:0] == `FSPS_KEY2 && key_state == 2'd1) begin
          key_state <= 2'd2;
        end else begin
          key_state <= 2'd0;
        end
      end else if (apb_wr) begin
        key_state <= 2'd0; // any other write disarms
      end
      if (apb_wr && paddr == `FSPS_PAGE_OFF) begin
        table_page_reg <= pwdata[7:0];
      end
      // ctrl writes while busy are dropped so the running op keeps its mode
      if (apb_wr && paddr == `FSPS_CTRL_OFF && !busy) begin
        flash_control_reg[`FSPS_WRITE_ALLOW_BIT_BIT:0] <= pwdata[`FSPS_WRITE_ALLOW_BIT_BIT:0];
        // start only after unlock with write enable set
        if (pwdata[`FSPS_WR_BIT] && key_state == 2'd2 && pwdata[`FSPS_WRITE_ALLOW_BIT_BIT]) begin
          flash_control_reg[`FSPS_WR_BIT] <= 1'b1;
        end
      end
      // self-clear on completion
      if (state == S_WAIT) begin
        flash_control_reg[`FSPS_WR_BIT] <= 1'b0;
      end
    end
  end

  // sequencer
  always @(posedge mclk) begin
    if (sys_rst) begin
      state     <= S_IDLE;
      timer     <= 16'h0000;
      base_addr <= 24'h000000;
      buf_ptr   <= 6'h00;
      op_cnt    <= 10'h000;
      hold_word <= 24'hffffff;
      tbl_rdata <= 16'h0000;
      fl_addr   <= 24'h000000;
      fl_wdata  <= 24'h000000;
      fl_we     <= 1'b0;
      fl_erase  <= 1'b0;
      fl_rd     <= 1'b0;
    end else if (clk_en) begin
      fl_we    <= 1'b0;
      fl_erase <= 1'b0;
      fl_rd    <= 1'b0;
      case (state)
        S_IDLE: begin
          if (flash_control_reg[`FSPS_WR_BIT] && flash_control_reg[`FSPS_WRITE_ALLOW_BIT_BIT]) begin
            buf_ptr <= 6'h00;
            op_cnt  <= 10'h000;
            timer   <= 16'h0000;
            // operation select, qualified by erase flag
            if (op_sel == `FSPS_OP_ERASE && flash_control_reg[`FSPS_ERASE_BIT]) begin
              state <= S_ERASE;
            end else if (op_sel == `FSPS_OP_ROW && !flash_control_reg[`FSPS_ERASE_BIT]) begin
              state <= S_ROW;
            end else if (op_sel == `FSPS_OP_WORD && !flash_control_reg[`FSPS_ERASE_BIT]) begin
              state <= S_WORD;
            end else begin
              state <= S_WAIT;
            end
          end else if (tbl_req && tbl_write) begin
            // holding buffer only, finished in two cycles
            hold_word <= buf_wdata;
            base_addr <= tbl_addr;
            state     <= S_TWR;
          end else if (tbl_req) begin
            // reads run beside the application, no special mode
            fl_addr <= tbl_addr;
            fl_rd   <= 1'b1;
            state   <= S_TRD;
          end
        end
        S_TWR: state <= S_IDLE;
        S_TRD: state <= S_TRD2;
        S_TRD2: begin
          tbl_rdata <= tbl_high ? {8'h00, fl_rdata[23:16]} : fl_rdata[15:0];
          state     <= S_IDLE;
        end
        S_ROW: begin
          // one row only, 64 words from the row-aligned base
          // buffer read is registered, so array writes trail buf_ptr by one
          timer    <= timer + 16'd1;
          fl_we    <= (timer >= 16'd1) && (timer <= 16'd64);
          fl_addr  <= {base_addr[23:7], (buf_ptr - 6'd1), 1'b0};
          fl_wdata <= buf_rdata;
          if (timer <= 16'd63) begin
            buf_ptr <= buf_ptr + 6'd1;
          end
          if (timer == `FSPS_ROW_CYC) begin
            state <= S_WAIT;
          end
        end
        S_WORD: begin
          // single word from its buffer slot
          timer <= timer + 16'd1;
          if (timer == 16'd0) begin
            buf_ptr <= base_addr[6:1];
          end
          if (timer == 16'd2) begin
            fl_we    <= 1'b1;
            fl_addr  <= base_addr;
            fl_wdata <= buf_rdata;
          end
          if (timer == `FSPS_WORD_CYC) begin
            state <= S_WAIT;
          end
        end
        S_ERASE: begin
          // whole page of 8 rows set to ones
          // page base comes from the dummy table write that set base_addr
          timer <= timer + 16'd1;
          if (op_cnt < `FSPS_ROW_WORDS * `FSPS_PAGE_ROWS) begin
            fl_erase <= 1'b1;
            fl_we    <= 1'b1;
            fl_wdata <= 24'hffffff;
            fl_addr  <= {base_addr[23:10], op_cnt[8:0], 1'b0};
            op_cnt   <= op_cnt + 10'd1;
          end
          if (timer == `FSPS_ERASE_CYC) begin
            state <= S_WAIT;
          end
        end
        S_WAIT: begin
          // spare cycle so the start bit clears before the core resumes
          state   <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule

// *** hw/fsps_map.vh ***
`ifndef FSPS_MAP_VH
`define FSPS_MAP_VH
// apb register byte offsets
`define FSPS_CTRL_OFF    12'h000
`define FSPS_KEY_OFF     12'h004
`define FSPS_PAGE_OFF    12'h008
`define FSPS_STAT_OFF    12'h00c
// control register fields
`define FSPS_WR_BIT      15
`define FSPS_WRITE_ALLOW_BIT_BIT    14
`define FSPS_ERASE_BIT   6
`define FSPS_OP_HI       3
`define FSPS_OP_LO       0
`define FSPS_CTRL_RST    16'h0000
`define FSPS_PAGE_RST    8'h00
// operation codes and key values
`define FSPS_OP_ERASE    4'h2
`define FSPS_OP_ROW      4'h1
`define FSPS_OP_WORD     4'h3
`define FSPS_KEY1        8'h55
`define FSPS_KEY2        8'haa
// geometry: instructions per row and rows per page
`define FSPS_ROW_WORDS   64
`define FSPS_PAGE_ROWS   8
// operation times in cycles of mclk
`define FSPS_ROW_CYC     16'd15000
`define FSPS_ERASE_CYC   16'd20000
`define FSPS_WORD_CYC    16'd500
`define FSPS_TBLWR_CYC   2
`endif

// *** hw/fsps_mem.v ***
/*
 single-port word memory with registered read data.
 assumes one access per cycle; a read during a write returns the old word.
*/
`timescale 1ns/1ns
module fsps_mem #(
  parameter AW = 6,
  parameter DW = 24
) (
  input  wire          mclk,
  input  wire          ce,
  input  wire          we,
  input  wire [AW-1:0] addr,
  input  wire [DW-1:0] wdata,
  output reg  [DW-1:0] rdata
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge mclk) begin
    if (ce) begin
      if (we) begin
        mem[addr] <= wdata;
      end
      rdata <= mem[addr];
    end
  end
endmodule

// *** tb/fsps_flash_model.sv ***
/*
 flash array model standing behind the sequencer's array port.
 assumes read data is sampled at the second edge after fl_rd rises.
*/
`timescale 1ns/1ns
module fsps_flash_model (
  input  wire        mclk,
  input  wire [23:0] fl_addr,
  input  wire [23:0] fl_wdata,
  input  wire        fl_we,
  input  wire        fl_rd,
  output reg  [23:0] fl_rdata
);
  logic [23:0] mem [int];
  initial fl_rdata = 24'h0;
  // blank cells read their own address, so a stray access shows up
  always @(posedge mclk) begin
    if (fl_we) mem[fl_addr] = fl_wdata;
    // data stands the cycle after fl_rd; otherwise the bus toggles
    if (fl_rd) fl_rdata <= mem.exists(fl_addr) ? mem[fl_addr] : fl_addr;
    else fl_rdata <= ~fl_rdata;
  end
endmodule

// *** tb/fsps_checker.sv ***
/*
 port assertions for the flash self-program sequencer.
 assumes binding into fsps_top, single mclk domain.
*/
`timescale 1ns/1ns
module fsps_checker (
  input wire        mclk,
  input wire        sys_rst,
  input wire        tbl_req,
  input wire        tbl_write,
  input wire [15:0] effective_address,
  input wire        tbl_done,
  input wire        core_stall,
  input wire [23:0] fl_addr,
  input wire [23:0] fl_wdata,
  input wire        fl_we,
  input wire        fl_erase,
  input wire        fl_rd,
  input wire        prog_clock_pin,
  input wire        prog_data_pin_oe_n,
  input wire        serial_prog_active
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_write_two_cyc: assert property (
    $rose(tbl_req) && tbl_write && !core_stall |=> tbl_done) else $error("table write late");
  a_read_fetch_addr: assert property (
    $rose(tbl_req) && !tbl_write && !core_stall |=> fl_rd && fl_addr[15:0] == $past(effective_address))
    else $error("table read fetch wrong");
  a_read_done_time: assert property (
    $rose(tbl_req) && !tbl_write && !core_stall |-> ##[2:3] tbl_done) else $error("table read late");
  a_done_one_pulse: assert property (tbl_done |=> !tbl_done) else $error("done longer than one cycle");
  a_stall_blocks: assert property (core_stall |-> !tbl_done) else $error("table op during stall");
  a_array_write_stalled: assert property (fl_we |-> core_stall) else $error("array write while idle");
  a_erase_all_ones: assert property (fl_we && fl_erase |-> fl_wdata == 24'hffffff)
    else $error("erase data not ones");
  a_erase_page_base: assert property ($rose(fl_we) && fl_erase |-> fl_addr[9:0] == 10'h000)
    else $error("erase not from page base");
  a_pin_released: assert property (prog_data_pin_oe_n) else $error("data pin driven");
  a_serial_seen: assert property (prog_clock_pin [*6] |-> serial_prog_active)
    else $error("serial pin not seen");
endmodule
bind fsps_top fsps_checker chk_u (.mclk, .sys_rst, .tbl_req, .tbl_write, .effective_address, .tbl_done,
  .core_stall, .fl_addr, .fl_wdata, .fl_we, .fl_erase, .fl_rd, .prog_clock_pin, .prog_data_pin_oe_n,
  .serial_prog_active);

// *** tb/fsps_top_tb.sv ***
/*
 self-checking bench: apb master, core table port, flash model.
 assumes fsps_top with zero-wait apb and macro operation times.
*/
`timescale 1ns/1ns
`include "fsps_map.vh"
module fsps_top_tb;
  logic        mclk = 0, sys_rst = 1, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic        pready, pslverr, tbl_req = 0, tbl_write = 0, tbl_high = 0, tbl_byte = 0, tbl_bsel = 0;
  logic [15:0] effective_address = 0, tbl_wdata = 0, tbl_rdata, lo;
  logic        tbl_done, core_stall, fl_we, fl_erase, fl_rd, prog_clock_pin = 0, prog_data_pin_in = 0;
  logic [23:0] fl_addr, fl_wdata, fl_rdata, exp_mem [int], hold_buf [64];
  logic        prog_data_pin_out, prog_data_pin_oe_n, serial_prog_active;
  logic [7:0]  page;
  int          fails = 0, tests_run = 0, seed = 51117, n, k;
  fsps_top dut_u (
    .mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tbl_req(tbl_req), .tbl_write(tbl_write), .tbl_high(tbl_high), .tbl_byte(tbl_byte), .tbl_bsel(tbl_bsel),
    .effective_address(effective_address), .tbl_wdata(tbl_wdata), .tbl_rdata(tbl_rdata), .tbl_done(tbl_done),
    .core_stall(core_stall), .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_we(fl_we), .fl_erase(fl_erase),
    .fl_rd(fl_rd), .fl_rdata(fl_rdata), .prog_clock_pin(prog_clock_pin), .prog_data_pin_in(prog_data_pin_in),
    .prog_data_pin_out(prog_data_pin_out), .prog_data_pin_oe_n(prog_data_pin_oe_n),
    .serial_prog_active(serial_prog_active));
  fsps_flash_model flash_u (.mclk(mclk), .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_we(fl_we), .fl_rd(fl_rd),
    .fl_rdata(fl_rdata));
  always #50 mclk = ~mclk;
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] expv);
    tests_run++;
    if (seen !== expv) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, expv, seen);
    end
  endtask
  task summarize();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  // one table op; also keeps the holding-buffer model
  task tbl(input logic w, input logic h, input logic [15:0] ea, input logic [15:0] wd);
    @(posedge mclk);
    tbl_req <= 1;
    tbl_write <= w;
    tbl_high <= h;
    effective_address <= ea;
    tbl_wdata <= wd;
    @(posedge mclk);
    for (n = 0; n < 9 && tbl_done !== 1'b1; n++) @(posedge mclk);
    tbl_req <= 0;
    @(posedge mclk);
    r = {16'h0, tbl_rdata};
    if (w && !h && !tbl_byte) hold_buf[ea[6:1]][15:0] = wd;
    if (w && !h && tbl_byte && tbl_bsel) hold_buf[ea[6:1]][15:8] = wd[7:0];
    if (w && !h && tbl_byte && !tbl_bsel) hold_buf[ea[6:1]][7:0] = wd[7:0];
    if (w && h) hold_buf[ea[6:1]][23:16] = wd[7:0];
  endtask
  function logic [23:0] ex(input int a);
    return exp_mem.exists(a) ? exp_mem[a] : a[23:0];
  endfunction
  task rdw(input logic [15:0] ea);
    tbl(0, 0, ea, 16'h0);
    lo = r[15:0];
    tbl(0, 1, ea, 16'h0);
    chk("word", {r[7:0], lo}, ex({page, ea}));
  endtask
  task start(input logic [15:0] ctl);
    apb(1, `FSPS_KEY_OFF, 32'h55);
    apb(1, `FSPS_KEY_OFF, 32'haa);
    apb(1, `FSPS_CTRL_OFF, {16'h0, ctl});
    @(posedge mclk);
    chk("stall", core_stall, 1);
    for (n = 0; n < 25000 && core_stall === 1'b1; n++) @(posedge mclk);
    apb(0, `FSPS_CTRL_OFF, 0);
    chk("start bit", r[15], 0);
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    sys_rst <= 0;
    apb(0, `FSPS_CTRL_OFF, 0);
    chk("ctrl reset", r, 0);
    apb(1, 12'h010, 32'hffffffff);
    apb(0, 12'h010, 0);
    chk("unmapped", r, 0);
    chk("slverr", pslverr, 0);
    page = 8'($random(seed));
    apb(1, `FSPS_PAGE_OFF, {24'h0, page});
    apb(0, `FSPS_PAGE_OFF, 0);
    chk("page", r, {24'h0, page});
    tbl(1, 0, 16'h0456, 16'h0);
    start(16'hc042);
    for (k = 0; k < 512; k++) exp_mem[{page, 16'h0400} + 2 * k] = 24'hffffff;
    rdw(16'h0400);
    rdw(16'h07fe);
    rdw(16'h03fe);
    rdw(16'h0800);
    for (k = 0; k < 64; k++) begin
      tbl(1, 0, 16'h0480 + 2 * k, 16'($random(seed)));
      tbl(1, 1, 16'h0480 + 2 * k, 16'($random(seed)) & 16'h00ff);
    end
    // keys split by another write must not arm
    apb(1, `FSPS_KEY_OFF, 32'h55);
    apb(1, `FSPS_PAGE_OFF, {24'h0, page});
    apb(1, `FSPS_KEY_OFF, 32'haa);
    apb(1, `FSPS_CTRL_OFF, 32'hc001);
    repeat (3) @(posedge mclk);
    chk("no start", core_stall, 0);
    start(16'hc001);
    for (k = 0; k < 64; k++) exp_mem[{page, 16'h0480} + 2 * k] = hold_buf[k];
    for (k = 0; k < 64; k++) rdw(16'h0480 + 2 * k);
    rdw(16'h0500);
    rdw(16'h047e);
    tbl(1, 0, 16'h0612, 16'($random(seed)));
    tbl(1, 1, 16'h0612, 16'($random(seed)) & 16'h00ff);
    // byte lanes of the low word, upper then lower
    tbl_byte <= 1;
    tbl_bsel <= 1;
    tbl(1, 0, 16'h0612, 16'($random(seed)));
    tbl_bsel <= 0;
    tbl(1, 0, 16'h0612, 16'($random(seed)));
    tbl_byte <= 0;
    start(16'hc003);
    exp_mem[{page, 16'h0612}] = hold_buf[9];
    rdw(16'h0612);
    rdw(16'h0610);
    prog_clock_pin <= 1;
    repeat (8) @(posedge mclk);
    chk("serial", serial_prog_active, 1);
    chk("data pin out", prog_data_pin_out, 0);
    prog_clock_pin <= 0;
    summarize();
  end
  // operations need about 36k cycles
  initial begin
    repeat (80000) @(posedge mclk);
    fails++;
    summarize();
  end
endmodule
